// ==== shared/pst_pkg.sv ====
package pst_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int PST_ADDR_W = 5;
    localparam int PST_DATA_W = 16;
    localparam logic [PST_ADDR_W-1:0] PST_LIVE_STATUS_OFFS = 5'h11;
    localparam logic [PST_ADDR_W-1:0] PST_IRQ_ENABLE_OFFS = 5'h12;

    // ------------------------------------------------------------
    // Live status field positions
    // ------------------------------------------------------------
    localparam int PST_ST_SPEED_HI = 15;
    localparam int PST_ST_SPEED_LO = 14;
    localparam int PST_ST_DUPLEX = 13;
    localparam int PST_ST_PAGE_RX = 12;
    localparam int PST_ST_RESOLVED = 11;
    localparam int PST_ST_LINK = 10;
    localparam int PST_ST_RSVD_HI = 9;
    localparam int PST_ST_RSVD_LO = 7;
    localparam int PST_ST_SWAP = 6;
    localparam int PST_ST_DOWNGRADE = 5;
    localparam int PST_ST_ZERO_HI = 4;
    localparam int PST_ST_ZERO_LO = 2;
    localparam int PST_ST_POLARITY = 1;
    localparam int PST_ST_JABBER = 0;
    localparam logic [2:0] PST_ST_RSVD_VALUE = 3'h7;
    localparam logic [2:0] PST_ST_ZERO_VALUE = 3'h0;

    // ------------------------------------------------------------
    // Speed encoding
    // ------------------------------------------------------------
    localparam logic [1:0] PST_SPEED_10 = 2'h0;
    localparam logic [1:0] PST_SPEED_100 = 2'h1;
    localparam logic [1:0] PST_SPEED_1000 = 2'h2;
    localparam logic [1:0] PST_SPEED_RSVD = 2'h3;

    // ------------------------------------------------------------
    // Interrupt enable register
    // ------------------------------------------------------------
    localparam logic [PST_DATA_W-1:0] PST_IRQ_ENABLE_RESET = 16'h0000;
    // Bits 15..10, 6, 5, 1 and 0 gate events; the rest are storage only.
    localparam logic [PST_DATA_W-1:0] PST_IRQ_VALID_MASK = 16'hFC63;
    localparam logic [PST_DATA_W-1:0] PST_READ_UNMAPPED = 16'h0000;

    // ------------------------------------------------------------
    // Pair swap selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PST_SWAP_STRAIGHT = 2'h0,
        PST_SWAP_CROSSED = 2'h1,
        PST_SWAP_RESERVED = 2'h2,
        PST_SWAP_AUTO = 2'h3
    } pst_swap_mode_t;

    localparam pst_swap_mode_t PST_SWAP_RESET = PST_SWAP_AUTO;

    // ------------------------------------------------------------
    // Live state arriving from the transceiver core
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] speed;
        logic fullDuplex;
        logic pageReceived;
        logic anComplete;
        logic anEnabled;
        logic linkUp;
        logic autoCrossed;
        logic downgraded;
        logic polarityReversed;
        logic jabber;
    } pst_live_t;

endpackage

// ==== hw/pst_sync.sv ====
`timescale 1ns/10ps

module pst_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage2_next;

    // Refused at elaboration, so a bad width never reaches simulation.
    if (WIDTH < 1) begin
        $error("pst_sync needs WIDTH of at least one");
    end

    // ------------------------------------------------------------
    // Two-stage synchroniser; the first stage feeds only the second.
    // ------------------------------------------------------------
    always_comb begin
        stage1_next = asyncIn;
        stage2_next = stage1_reg;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    assign syncOut = stage2_reg;

endmodule

// ==== hw/pst_status_regs.sv ====
`timescale 1ns/10ps

// Overview of operation
// [RULE_01] Speed field 15:14: 10, 100, 1000 Mbps.
// [RULE_02] Speed, duplex, swap meaningful only when resolved.
// [RULE_03] Resolved flag: negotiation done or disabled.
// [RULE_04] Bit 13 reads duplex, one is full.
// [RULE_05] Bit 12 shows page received live.
// [RULE_06] Bit 10 shows live link state, unlatched.
// [RULE_07] Reserved bits 9:7 always read 111.
// [RULE_08] Bit 6 reports crossed pairs per mode.
// [RULE_09] Bit 5 reports automatic speed downgrade.
// [RULE_10] Bit 1 tracks reversed receive polarity.
// [RULE_11] Bit 0 tracks current transmit jabber.
// [RULE_12] Enable bits gate interrupts, reset to zero.
// [RULE_13] Swap mode: straight, crossed, reserved, automatic.
// [RULE_14] Only enabled events raise the interrupt.
// [RULE_15] Reserved enable bits store but do nothing.

module pst_status_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire logic swReset,
    input pst_pkg::pst_live_t liveIn,
    input wire logic [1:0] pairSwapSelect,
    input wire logic [pst_pkg::PST_DATA_W-1:0] eventLatched,
    input wire logic [pst_pkg::PST_ADDR_W-1:0] regAddr,
    input wire logic regWrEn,
    input wire logic [pst_pkg::PST_DATA_W-1:0] regWrData,
    input wire logic regRdEn,
    output logic [pst_pkg::PST_DATA_W-1:0] regRdData,
    output logic regRdAck,
    output logic regRdHit,
    output logic pairSwapState,
    output logic irqOut
);

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    function automatic logic isMapped(input logic [pst_pkg::PST_ADDR_W-1:0] addr);
        isMapped = (addr == pst_pkg::PST_LIVE_STATUS_OFFS) || (addr == pst_pkg::PST_IRQ_ENABLE_OFFS);
    endfunction

    function automatic logic isEnableReg(input logic [pst_pkg::PST_ADDR_W-1:0] addr);
        isEnableReg = (addr == pst_pkg::PST_IRQ_ENABLE_OFFS);
    endfunction

    // ------------------------------------------------------------
    // Live inputs
    // ------------------------------------------------------------
    // The core state comes from the line-side logic, which is not on
    // the management clock, so every bit is synchronised first. Multi-bit
    // speed may show one mixed sample while it changes; software only
    // trusts it while resolved, which is stable long after speed settles.
    pst_pkg::pst_live_t liveSync;

    pst_sync #(
        .WIDTH($bits(pst_pkg::pst_live_t))
    ) u_live_sync (
        .clk(clk),
        .rstn(rstn),
        .asyncIn(liveIn),
        .syncOut(liveSync)
    );

    // ------------------------------------------------------------
    // Pair swap mode
    // ------------------------------------------------------------
    pst_pkg::pst_swap_mode_t swapMode_reg;
    pst_pkg::pst_swap_mode_t swapMode_next;
    logic crossedNow;

    always_comb begin
        swapMode_next = swapMode_reg;
        // A new selection is taken only at software reset.
        if (swReset) begin // RULE_08
            swapMode_next = pst_pkg::pst_swap_mode_t'(pairSwapSelect);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            swapMode_reg <= pst_pkg::PST_SWAP_RESET;
        end else begin
            swapMode_reg <= swapMode_next;
        end
    end

    always_comb begin
        case (swapMode_reg) // RULE_13
            pst_pkg::PST_SWAP_STRAIGHT: begin
                crossedNow = 1'b0;
            end
            pst_pkg::PST_SWAP_CROSSED: begin
                crossedNow = 1'b1;
            end
            pst_pkg::PST_SWAP_AUTO: begin
                crossedNow = liveSync.autoCrossed;
            end
            default: begin
                // The reserved code behaves as automatic so the link still works.
                crossedNow = liveSync.autoCrossed;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Live status word
    // ------------------------------------------------------------
    logic resolved;
    logic [pst_pkg::PST_DATA_W-1:0] statusWord;

    assign resolved = liveSync.anComplete || !liveSync.anEnabled; // RULE_03

    always_comb begin
        statusWord = '0;
        // Resolution-dependent fields read zero until resolved.
        if (resolved) begin // RULE_02
            statusWord[pst_pkg::PST_ST_SPEED_HI:pst_pkg::PST_ST_SPEED_LO] = liveSync.speed; // RULE_01
            statusWord[pst_pkg::PST_ST_DUPLEX] = liveSync.fullDuplex; // RULE_04
            statusWord[pst_pkg::PST_ST_SWAP] = crossedNow; // RULE_08
        end
        statusWord[pst_pkg::PST_ST_PAGE_RX] = liveSync.pageReceived; // RULE_05
        statusWord[pst_pkg::PST_ST_RESOLVED] = resolved; // RULE_03
        statusWord[pst_pkg::PST_ST_LINK] = liveSync.linkUp; // RULE_06
        statusWord[pst_pkg::PST_ST_RSVD_HI:pst_pkg::PST_ST_RSVD_LO] = pst_pkg::PST_ST_RSVD_VALUE; // RULE_07
        statusWord[pst_pkg::PST_ST_DOWNGRADE] = liveSync.downgraded; // RULE_09
        statusWord[pst_pkg::PST_ST_ZERO_HI:pst_pkg::PST_ST_ZERO_LO] = pst_pkg::PST_ST_ZERO_VALUE;
        statusWord[pst_pkg::PST_ST_POLARITY] = liveSync.polarityReversed; // RULE_10
        statusWord[pst_pkg::PST_ST_JABBER] = liveSync.jabber; // RULE_11
    end

    // ------------------------------------------------------------
    // Interrupt enable register
    // ------------------------------------------------------------
    logic [pst_pkg::PST_DATA_W-1:0] irqEnable_reg;
    logic [pst_pkg::PST_DATA_W-1:0] irqEnable_next;

    always_comb begin
        irqEnable_next = irqEnable_reg;
        // Software reset wins over a write landing in the same cycle.
        if (swReset) begin
            irqEnable_next = pst_pkg::PST_IRQ_ENABLE_RESET; // RULE_12
        end else if (regWrEn && isEnableReg(regAddr)) begin
            irqEnable_next = regWrData; // RULE_12
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqEnable_reg <= pst_pkg::PST_IRQ_ENABLE_RESET;
        end else begin
            irqEnable_reg <= irqEnable_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt indication
    // ------------------------------------------------------------
    // Recorded events stay in the latched status outside; only those with
    // an enable bit set, on a defined position, reach the line.
    logic irq_reg;
    logic irq_next;

    always_comb begin
        irq_next = |(eventLatched & irqEnable_reg & pst_pkg::PST_IRQ_VALID_MASK); // RULE_14 RULE_15
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [pst_pkg::PST_DATA_W-1:0] rdData_reg;
    logic [pst_pkg::PST_DATA_W-1:0] rdData_next;
    logic rdAck_reg;
    logic rdAck_next;
    logic rdHit_reg;
    logic rdHit_next;
    logic swap_reg;
    logic swap_next;

    always_comb begin
        rdData_next = rdData_reg;
        rdAck_next = regRdEn;
        rdHit_next = 1'b0;
        if (regRdEn) begin
            rdHit_next = isMapped(regAddr);
            if (!isMapped(regAddr)) begin
                rdData_next = pst_pkg::PST_READ_UNMAPPED;
            end else if (isEnableReg(regAddr)) begin
                rdData_next = irqEnable_reg;
            end else begin
                rdData_next = statusWord;
            end
        end
        swap_next = statusWord[pst_pkg::PST_ST_SWAP];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdData_reg <= '0;
            rdAck_reg <= 1'b0;
            rdHit_reg <= 1'b0;
            swap_reg <= 1'b0;
        end else begin
            rdData_reg <= rdData_next;
            rdAck_reg <= rdAck_next;
            rdHit_reg <= rdHit_next;
            swap_reg <= swap_next;
        end
    end

    assign regRdData = rdData_reg;
    assign regRdAck = rdAck_reg;
    assign regRdHit = rdHit_reg;
    assign pairSwapState = swap_reg;
    assign irqOut = irq_reg;

endmodule

// ==== verification/pst_status_monitor.sv ====
`timescale 1ns/10ps

module pst_status_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic swReset,
    input wire logic [15:0] eventLatched,
    input wire logic [4:0] regAddr,
    input wire logic regRdEn,
    input wire logic [15:0] regRdData,
    input wire logic regRdAck,
    input wire logic regRdHit,
    input wire logic pairSwapState,
    input wire logic irqOut
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_read_gets_ack: assert property (regRdEn |=> regRdAck)
        else $error("read strobe not answered");
    a_ack_needs_read: assert property (regRdAck |-> $past(regRdEn))
        else $error("answer without read");
    a_rsvd_ones: assert property (regRdEn && regAddr == 5'h11 |=> regRdHit && regRdData[9:7] == 3'h7)
        else $error("status bits 9:7 not ones");
    a_zero_field: assert property (regRdEn && regAddr == 5'h11 |=> regRdData[4:2] == 3'h0)
        else $error("status bits 4:2 not zero");
    a_unresolved_blank: assert property (regRdAck && $past(regAddr) == 5'h11 && !regRdData[11]
        |-> regRdData[15:13] == 3'h0 && !regRdData[6])
        else $error("unresolved fields not blank");
    a_swap_copy: assert property (regRdAck && $past(regAddr) == 5'h11 && $stable(pairSwapState)
        |-> regRdData[6] == pairSwapState)
        else $error("swap pin differs from status");
    a_irq_gated: assert property ((eventLatched & 16'hFC63) == 16'h0000 |=> !irqOut)
        else $error("interrupt without gated event");
    a_swrst_quiet: assert property (swReset |-> ##2 !irqOut)
        else $error("interrupt after soft reset");

    c_status_read: cover property (regRdEn && regAddr == 5'h11);
    c_irq_high: cover property (irqOut);
    c_soft_reset: cover property (swReset);
endmodule

bind pst_status_regs pst_status_monitor u_pst_status_monitor (.clk(clk), .rstn(rstn), .swReset(swReset),
    .eventLatched(eventLatched), .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdAck(regRdAck), .regRdHit(regRdHit), .pairSwapState(pairSwapState), .irqOut(irqOut));

// ==== verification/pst_mgmt_model.sv ====
`timescale 1ns/10ps

// Station manager side: issues one register access at a time.
module pst_mgmt_model (
    input wire logic clk,
    input wire logic [15:0] regRdData,
    input wire logic regRdAck,
    input wire logic regRdHit,
    output logic [4:0] regAddr,
    output logic regWrEn,
    output logic [15:0] regWrData,
    output logic regRdEn
);
    initial begin
        regAddr = 5'h00;
        regWrEn = 1'b0;
        regWrData = 16'h0000;
        regRdEn = 1'b0;
    end

    // Released lines show the inverse so stale values never pass by luck.
    task wr(input logic [4:0] a, input logic [15:0] v);
        @(negedge clk);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~v;
    endtask

    task rd(input logic [4:0] a, output logic [15:0] v, output logic hit);
        @(negedge clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        v = regRdAck ? regRdData : 16'hXXXX;
        hit = regRdHit;
    endtask
endmodule

// ==== verification/tb_pst_status_regs.sv ====
`timescale 1ns/10ps

module tb_pst_status_regs;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic swReset = 1'b0;
    pst_pkg::pst_live_t liveIn = '0;
    logic [1:0] pairSwapSelect = 2'h3;
    logic [15:0] eventLatched = 16'h0000;
    logic [15:0] regRdData, regWrData, d;
    logic [4:0] regAddr;
    logic regWrEn, regRdEn, regRdAck, regRdHit, pairSwapState, irqOut, h;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    pst_status_regs u_pst_status_regs (.clk(clk), .rstn(rstn), .swReset(swReset), .liveIn(liveIn),
        .pairSwapSelect(pairSwapSelect), .eventLatched(eventLatched), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdAck(regRdAck),
        .regRdHit(regRdHit), .pairSwapState(pairSwapState), .irqOut(irqOut));

    pst_mgmt_model u_pst_mgmt_model (.clk(clk), .regRdData(regRdData), .regRdAck(regRdAck),
        .regRdHit(regRdHit), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task rd(input logic [4:0] a);
        u_pst_mgmt_model.rd(a, d, h);
    endtask

    function automatic logic [15:0] expSt(input pst_pkg::pst_live_t l, input logic sw);
        logic r;
        r = l.anComplete | ~l.anEnabled;
        expSt = {r ? {l.speed, l.fullDuplex} : 3'h0, l.pageReceived, r, l.linkUp, 3'h7, r & sw,
            l.downgraded, 3'h0, l.polarityReversed, l.jabber};
    endfunction

    task report_and_stop();
        $display("TB: %0d comparisons, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset();
        rd(5'h12);
        chk("enableReset", 16'h0000, d);
        rd(5'h05);
        chk("unmappedRdData", 16'h0000, d);
        chk("unmappedRdHit", 16'h0000, {15'h0, h});
        $display("done t_reset");
    endtask

    // Mode is auto after reset, so bit 6 follows the crossed input.
    task t_status();
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            liveIn = {2'(i + 1), ~i[0], i[0], i < 4, i == 4, ~i[0], 1'b1, i[1], i[0], ~i[1]};
            repeat (3) @(negedge clk);
            rd(5'h11);
            chk("status", expSt(liveIn, 1'b1), d);
            chk("statusHit", 16'h0001, {15'h0, h});
        end
        $display("done t_status");
    endtask

    // Both crossed-input levels, so forced modes must ignore it and the others follow it.
    task t_swap();
        for (int x = 0; x < 2; x++) begin
            for (int m = 0; m < 4; m++) begin
                @(negedge clk);
                liveIn = '{anComplete: 1'b1, autoCrossed: x[0], default: '0};
                pairSwapSelect = 2'(m);
                swReset = 1'b1;
                @(negedge clk);
                swReset = 1'b0;
                repeat (2) @(negedge clk);
                rd(5'h11);
                chk("swapBit", {15'h0, m == 1 || (m > 1 && x[0])}, {15'h0, d[6]});
                chk("swapPin", {15'h0, m == 1 || (m > 1 && x[0])}, {15'h0, pairSwapState});
            end
        end
        $display("done t_swap");
    endtask

    // Writes outside the enable register, or under soft reset, never land.
    task t_refuse();
        u_pst_mgmt_model.wr(5'h12, 16'h1234);
        u_pst_mgmt_model.wr(5'h11, 16'hFFFF);
        u_pst_mgmt_model.wr(5'h13, 16'hFFFF);
        u_pst_mgmt_model.wr(5'h02, 16'hFFFF);
        rd(5'h12);
        chk("enableKept", 16'h1234, d);
        rd(5'h13);
        chk("unmappedData", 16'h0000, d);
        chk("unmappedHit", 16'h0000, {15'h0, h});
        pairSwapSelect = 2'h0;
        fork
            u_pst_mgmt_model.wr(5'h12, 16'hFFFF);
            begin
                @(negedge clk);
                swReset = 1'b1;
                @(negedge clk);
                swReset = 1'b0;
            end
        join
        pairSwapSelect = 2'h3;
        rd(5'h12);
        chk("enableWrLost", 16'h0000, d);
        u_pst_mgmt_model.wr(5'h12, 16'h0400);
        @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        rd(5'h12);
        chk("enableHardRst", 16'h0000, d);
        rd(5'h11);
        chk("swapHardRst", 16'h0001, {15'h0, d[6]});
        $display("done t_refuse");
    endtask

    task t_irq();
        u_pst_mgmt_model.wr(5'h12, 16'hFFFF);
        rd(5'h12);
        chk("enableRw", 16'hFFFF, d);
        for (int b = 0; b < 16; b++) begin
            eventLatched = 16'h0001 << b;
            repeat (2) @(negedge clk);
            chk("irqBit", {15'h0, b != 2 && b != 3 && b != 4 && (b < 7 || b > 9)}, {15'h0, irqOut});
        end
        eventLatched = 16'hFFFF;
        u_pst_mgmt_model.wr(5'h12, 16'h0000);
        repeat (2) @(negedge clk);
        chk("irqMasked", 16'h0000, {15'h0, irqOut});
        u_pst_mgmt_model.wr(5'h12, 16'h0400);
        repeat (2) @(negedge clk);
        chk("irqOne", 16'h0001, {15'h0, irqOut});
        swReset = 1'b1;
        @(negedge clk);
        swReset = 1'b0;
        rd(5'h12);
        chk("enableSoftRst", 16'h0000, d);
        chk("irqSoftRst", 16'h0000, {15'h0, irqOut});
        eventLatched = 16'h0000;
        $display("done t_irq");
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        t_reset();
        t_status();
        t_swap();
        t_irq();
        t_refuse();
        report_and_stop();
    end
endmodule
